//--- core/sltps_pkg.sv
package sltps_pkg;

   // ------------------------------------------------------------------
   // Geometry and register map
   // ------------------------------------------------------------------
   localparam int         NUM_LANES     = 4;
   localparam logic [1:0] ADR_PATTERN   = 2'h0;
   localparam logic [1:0] ADR_LINKCFG   = 2'h1;
   localparam logic [1:0] ADR_STATUS    = 2'h2;
   localparam int         PAT_MSB       = 4;
   localparam int         EN_BIT        = 0;
   localparam int         ENC_BIT       = 1;
   localparam int         STAT_EN_BIT   = 8;
   localparam logic [7:0] PATTERN_RST   = 8'h00;
   localparam logic [1:0] LINKCFG_RST   = 2'h2;

   // ------------------------------------------------------------------
   // Pattern select codes
   // ------------------------------------------------------------------
   localparam logic [4:0] PAT_NORMAL    = 5'h00;
   localparam logic [4:0] PAT_PRBS7     = 5'h01;
   localparam logic [4:0] PAT_PRBS15    = 5'h02;
   localparam logic [4:0] PAT_PRBS23    = 5'h03;
   localparam logic [4:0] PAT_RAMP      = 5'h04;
   localparam logic [4:0] PAT_TRANSPORT = 5'h05;
   localparam logic [4:0] PAT_D21_5     = 5'h06;
   localparam logic [4:0] PAT_K28_5     = 5'h07;
   localparam logic [4:0] PAT_ILA       = 5'h08;
   localparam logic [4:0] PAT_RPAT      = 5'h09;
   localparam logic [4:0] PAT_LOW       = 5'h0a;
   localparam logic [4:0] PAT_HIGH      = 5'h0b;
   localparam logic [4:0] PAT_PRBS9     = 5'h0d;
   localparam logic [4:0] PAT_PRBS31    = 5'h0e;
   localparam logic [4:0] PAT_CLOCK     = 5'h0f;
   localparam logic [4:0] PAT_K28_7     = 5'h10;

   // ------------------------------------------------------------------
   // Characters and fixed words
   // ------------------------------------------------------------------
   localparam logic [7:0]  CH_D21_5     = 8'hb5;
   localparam logic [7:0]  CH_K28_5     = 8'hbc;
   localparam logic [7:0]  CH_K28_7     = 8'hfc;
   localparam logic [7:0]  CH_K28_0     = 8'h1c;
   localparam logic [7:0]  CH_K28_3     = 8'h7c;
   localparam logic [15:0] CLK_WORD     = 16'h00ff;
   localparam logic [30:0] PRBS_SEED    = 31'h7fffffff;
   localparam logic [2:0]  RPAT_LAST    = 3'h5;
   localparam logic [15:0] RPAT_TBL [6] = '{16'hbe_d7, 16'h23_47, 16'h6b_8f,
                                          16'hb3_14, 16'h5e_fb, 16'h35_59};

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } sltps_wb_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } sltps_wb_rsp_type;

   typedef struct packed {
      logic [15:0] data;
      logic [1:0]  is_k;
      logic        raw;
   } sltps_lane_type;

endpackage : sltps_pkg

//--- core/sltps_top.sv
`timescale 1ns/1ns
// Functional notes
// [R01] Code 0 (reset value) passes converter data unchanged to every lane.
// [R02] Codes 1, 2, 3 send PRBS7, PRBS15, PRBS23 on every active lane.
// [R03] Codes 13 and 14 send PRBS9 and PRBS31 on every active lane.
// [R04] Code 4 sends a ramp, code 5 the transport-layer pattern.
// [R05] Code 6 repeats D21.5; code 7 repeats K28.5, only in 8b/10b.
// [R06] Code 8 repeats alignment sequence, code 9 modified RPAT, only 8b/10b.
// [R07] Code 10 holds every serial output low.
// [R08] Code 11 holds every serial output high.
// [R09] Code 15 repeats eight zeros then eight ones on every lane.
// [R10] Code 16 repeats K28.7, only in 8b/10b.
// [R11] Software picks 8b/10b-only codes only while link mode is 8b/10b.
// [R12] Software never writes reserved codes nor the upper three bits.
// [R13] Software changes the select only while the link is disabled.
module sltps_top
   import sltps_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire sltps_wb_req_type            wb_req,
   output sltps_wb_rsp_type                 wb_rsp,
   input  wire logic [NUM_LANES-1:0][15:0]  conv_data,
   output sltps_lane_type [NUM_LANES-1:0]   lane_out
);

   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------

   // Register decode, shared by write and read paths
   function automatic logic hit(input logic [3:0] adr, input logic [1:0] idx);
      return adr[3:2] == idx;
   endfunction : hit

   // Pattern actually in force; codes the link cannot carry fall back
   function automatic logic [4:0] eff_code(input logic [4:0] code,
                                           input logic [1:0] cfg);
      logic [4:0] res;
      res = PAT_NORMAL;
      if (cfg[EN_BIT]) begin
         case (code)
            PAT_PRBS7, PAT_PRBS15, PAT_PRBS23, PAT_RAMP, PAT_TRANSPORT,
            PAT_D21_5, PAT_LOW, PAT_HIGH, PAT_PRBS9, PAT_PRBS31,
            PAT_CLOCK: res = code;
            // Only reachable with an 8b/10b link mode
            PAT_K28_5, PAT_ILA, PAT_RPAT, PAT_K28_7: begin
               res = cfg[ENC_BIT] ? code : PAT_NORMAL; // see [R11]
            end
            // Reserved codes behave as normal data
            default: res = PAT_NORMAL; // see [R12]
         endcase
      end
      return res;
   endfunction : eff_code

   // Sixteen LFSR steps, oldest bit into data MSB; returns {state, word}
   function automatic logic [46:0] prbs16(input logic [30:0] s_in,
                                          input int len, input int tap);
      logic [30:0] s;
      logic [15:0] w;
      logic        fb;
      s = s_in;
      w = '0;
      fb = 1'b0;
      for (int i = 0; i < 16; i++) begin
         fb = s[len-1] ^ s[tap-1];
         s = {s[29:0], fb};
         w[15-i] = fb;
      end
      return {s, w};
   endfunction : prbs16

   // ------------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------------
   logic [7:0]       pat_r;
   logic [1:0]       cfg_r;
   logic [4:0]       eff_r;
   logic             en_r;
   sltps_wb_rsp_type rsp_r;
   logic             acc;
   logic             wr;
   logic [31:0]      rd_nxt;

   // One access per request; the ack cycle itself is never re-taken
   assign acc = wb_req.cyc & wb_req.stb & ~rsp_r.ack;
   assign wr  = acc & wb_req.we & wb_req.sel[0];

   // Read mux; unmapped addresses read zero and still get an ack
   always_comb begin
      rd_nxt = '0;
      if (hit(wb_req.adr, ADR_PATTERN)) begin
         rd_nxt[7:0] = pat_r;
      end else if (hit(wb_req.adr, ADR_LINKCFG)) begin
         rd_nxt[1:0] = cfg_r;
      end else if (hit(wb_req.adr, ADR_STATUS)) begin
         rd_nxt[PAT_MSB:0] = eff_r;
         rd_nxt[STAT_EN_BIT] = en_r;
      end
   end

   // Answer one cycle after the request, for one cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsp_r <= '0;
      end else begin
         rsp_r.ack <= acc;
         rsp_r.dat <= acc ? rd_nxt : '0;
      end
   end

   // Pattern select; full byte kept so reserved bits read back
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pat_r <= PATTERN_RST; // see [R01]
      end else if (wr && hit(wb_req.adr, ADR_PATTERN)) begin
         pat_r <= wb_req.dat[7:0];
      end
   end

   // Link enable and encoding mode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_r <= LINKCFG_RST;
      end else if (wr && hit(wb_req.adr, ADR_LINKCFG)) begin
         cfg_r <= wb_req.dat[1:0];
      end
   end

   assign wb_rsp = rsp_r;

   // ------------------------------------------------------------------
   // Pattern sequencing
   // ------------------------------------------------------------------
   logic [4:0]  eff_nxt;
   logic        restart;
   logic [7:0]  cnt_r;
   logic [2:0]  rpat_r;
   logic [30:0] prbs_r;
   logic [46:0] prbs_nxt;
   int          p_len;
   int          p_tap;

   // Sequences restart whenever the effective pattern changes, so a
   // select change made with the link live still yields clean patterns
   assign eff_nxt = eff_code(pat_r[PAT_MSB:0], cfg_r); // see [R13]
   assign restart = eff_nxt != eff_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eff_r <= PAT_NORMAL;
         en_r  <= 1'b0;
      end else begin
         eff_r <= eff_nxt;
         en_r  <= cfg_r[EN_BIT];
      end
   end

   // Shared beat counter for ramp, transport and alignment sequence
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= restart ? 8'h00 : cnt_r + 8'h01;
      end
   end

   // Modified RPAT index, wraps after six words
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rpat_r <= '0;
      end else if (restart || rpat_r == RPAT_LAST) begin
         rpat_r <= '0;
      end else begin
         rpat_r <= rpat_r + 3'h1;
      end
   end

   // Polynomial taps for the selected sequence
   always_comb begin
      case (eff_r)
         PAT_PRBS7:  begin p_len = 7;  p_tap = 6;  end // see [R02]
         PAT_PRBS15: begin p_len = 15; p_tap = 14; end // see [R02]
         PAT_PRBS23: begin p_len = 23; p_tap = 18; end // see [R02]
         PAT_PRBS9:  begin p_len = 9;  p_tap = 5;  end // see [R03]
         PAT_PRBS31: begin p_len = 31; p_tap = 28; end // see [R03]
         default:    begin p_len = 7;  p_tap = 6;  end
      endcase
   end

   assign prbs_nxt = prbs16(prbs_r, p_len, p_tap);

   // One generator serves all lanes; every lane carries the same bits
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prbs_r <= PRBS_SEED;
      end else begin
         prbs_r <= restart ? PRBS_SEED : prbs_nxt[46:16];
      end
   end

   // ------------------------------------------------------------------
   // Common lane word
   // ------------------------------------------------------------------
   logic [15:0] w_data;
   logic [1:0]  w_k;
   logic        w_raw;
   logic [7:0]  ramp_b;

   assign ramp_b = {cnt_r[6:0], 1'b0};

   // Raw words bypass the encoder; the rest are characters
   always_comb begin
      w_data = '0;
      w_k    = 2'b00;
      w_raw  = 1'b0;
      case (eff_r)
         PAT_PRBS7, PAT_PRBS15, PAT_PRBS23, PAT_PRBS9, PAT_PRBS31: begin
            w_data = prbs_nxt[15:0]; // see [R02] see [R03]
            w_raw  = 1'b1;
         end
         PAT_RAMP:  w_data = {ramp_b, ramp_b + 8'h01}; // see [R04]
         PAT_D21_5: w_data = {CH_D21_5, CH_D21_5}; // see [R05]
         PAT_K28_5: begin
            w_data = {CH_K28_5, CH_K28_5}; // see [R05]
            w_k    = 2'b11;
         end
         PAT_ILA: begin
            // Sixteen-beat frame: start marker, ramp body, end marker
            w_data = {ramp_b, ramp_b + 8'h01}; // see [R06]
            if (cnt_r[3:0] == 4'h0) begin
               w_data[15:8] = CH_K28_0;
               w_k = 2'b10;
            end else if (cnt_r[3:0] == 4'hf) begin
               w_data[7:0] = CH_K28_3;
               w_k = 2'b01;
            end
         end
         PAT_RPAT:  w_data = RPAT_TBL[rpat_r]; // see [R06]
         PAT_LOW: begin
            w_data = 16'h0000; // see [R07]
            w_raw  = 1'b1;
         end
         PAT_HIGH: begin
            w_data = 16'hffff; // see [R08]
            w_raw  = 1'b1;
         end
         PAT_CLOCK: begin
            w_data = CLK_WORD; // see [R09]
            w_raw  = 1'b1;
         end
         PAT_K28_7: begin
            w_data = {CH_K28_7, CH_K28_7}; // see [R10]
            w_k    = 2'b11;
         end
         default: w_data = '0;
      endcase
   end

   // ------------------------------------------------------------------
   // Lane output registers
   // ------------------------------------------------------------------
   genvar gl;
   generate
      for (gl = 0; gl < NUM_LANES; gl++) begin : g_lane
         sltps_lane_type ln_r;

         always_ff @(posedge clk) begin
            if (!rst_n) begin
               ln_r <= '0;
            end else if (!en_r) begin
               // Disabled link: lanes sit idle at zero
               ln_r <= '0;
            end else if (eff_r == PAT_NORMAL) begin
               ln_r <= '{data: conv_data[gl], is_k: 2'b00, raw: 1'b0}; // see [R01]
            end else if (eff_r == PAT_TRANSPORT) begin
               // Lane number in the top nibble tells lanes apart
               ln_r <= '{data: {4'(gl), 4'h0, ramp_b}, is_k: 2'b00, raw: 1'b0}; // see [R04]
            end else begin
               ln_r <= '{data: w_data, is_k: w_k, raw: w_raw};
            end
         end

         assign lane_out[gl] = ln_r;
      end
   endgenerate

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_normal_pass: assert property ( // see [R01]
      en_r && eff_r == PAT_NORMAL |=> lane_out[0].data == $past(conv_data[0]) && !lane_out[0].raw)
      else $error("normal data not passed through");

   chk_prbs7_poly: assert property ( // see [R02]
      en_r && eff_r == PAT_PRBS7 |=>
         lane_out[1].raw && lane_out[1].data[8:0] == (lane_out[1].data[15:7] ^ lane_out[1].data[14:6]))
      else $error("prbs7 word breaks its polynomial");

   chk_prbs9_poly: assert property ( // see [R03]
      en_r && eff_r == PAT_PRBS9 |=>
         lane_out[0].data[6:0] == (lane_out[0].data[15:9] ^ lane_out[0].data[11:5]))
      else $error("prbs9 word breaks its polynomial");

   chk_ramp_step: assert property ( // see [R04]
      en_r && eff_r == PAT_RAMP && $past(eff_r) == PAT_RAMP && !restart |=>
         lane_out[2].data[15:8] == $past(lane_out[2].data[7:0]) + 8'h01)
      else $error("ramp does not advance by one");

   chk_k28_5_char: assert property ( // see [R05]
      en_r && eff_r == PAT_K28_5 |=> lane_out[3].data == {CH_K28_5, CH_K28_5} && lane_out[3].is_k == 2'b11)
      else $error("k28.5 not repeated");

   chk_ila_marker: assert property ( // see [R06]
      $rose(en_r && eff_r == PAT_ILA) |-> ##[1:17] lane_out[0].data[15:8] == CH_K28_0 && lane_out[0].is_k[1])
      else $error("alignment start marker missing");

   chk_held_low: assert property ( // see [R07]
      en_r && eff_r == PAT_LOW |=> lane_out[0].data == 16'h0000 && lane_out[3].raw)
      else $error("outputs not held low");

   chk_held_high: assert property ( // see [R08]
      en_r && eff_r == PAT_HIGH |=> lane_out[1].data == 16'hffff && lane_out[1].raw)
      else $error("outputs not held high");

   chk_clock_word: assert property ( // see [R09]
      en_r && eff_r == PAT_CLOCK |=> lane_out[2].data == CLK_WORD)
      else $error("clock pattern wrong");

   chk_k28_7_mode: assert property ( // see [R10]
      eff_r == PAT_K28_7 |-> $past(cfg_r[ENC_BIT]) ##1
         lane_out[0].data == {CH_K28_7, CH_K28_7} && lane_out[0].is_k == 2'b11)
      else $error("k28.7 wrong or outside 8b/10b");

   chk_bus_ack: assert property (
      wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack ##1 !wb_rsp.ack)
      else $error("ack not a one-cycle answer");

endmodule : sltps_top

//--- sim/sltps_rx_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Receiver logic checking a PRBS lane
// ------------------------------------------------------------------
module sltps_rx_model
   import sltps_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire sltps_lane_type lane,
   input  wire logic [4:0]     tap_a,
   input  wire logic [4:0]     tap_b,
   output int                  bad_cnt,
   output int                  word_cnt
);
   logic [31:0] hist_r;
   logic [1:0]  fill_r;
   logic [47:0] win;

   // Newest bit sits at win[0], data MSB first
   assign win = {hist_r, lane.data};

   // History restarts whenever raw line bits stop
   always_ff @(posedge clk) begin
      if (!rst_n || !lane.raw) begin
         hist_r <= '0;
         fill_r <= 2'h0;
      end else begin
         hist_r <= win[31:0];
         fill_r <= (fill_r == 2'h2) ? fill_r : fill_r + 2'h1;
      end
   end

   // Self-synchronising, so no seed agreement is needed
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bad_cnt  <= 0;
         word_cnt <= 0;
      end else if (lane.raw && fill_r == 2'h2) begin
         word_cnt <= word_cnt + 1;
         for (int k = 0; k < 16; k++) begin
            if (win[k] != (win[k + tap_a] ^ win[k + tap_b])) begin
               bad_cnt <= bad_cnt + 1;
            end
         end
      end
   end
endmodule : sltps_rx_model

//--- sim/serial_lane_test_pattern_select_tb_top.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Bench for the lane pattern selector
// ------------------------------------------------------------------
module serial_lane_test_pattern_select_tb_top;
   import sltps_pkg::*;
   logic                           clk = 1'b0;
   logic                           rst_n;
   sltps_wb_req_type               wb_req;
   sltps_wb_rsp_type               wb_rsp;
   logic [NUM_LANES-1:0][15:0]     conv_data;
   sltps_lane_type [NUM_LANES-1:0] lane_out;
   logic [4:0]                     tap_a;
   logic [4:0]                     tap_b;
   logic [31:0]                    rd;
   int                             bad_cnt;
   int                             word_cnt;
   int                             err_count = 0;
   int                             num_checks = 0;
   int                             cyc_cnt = 0;

   // 20 MHz clock
   always #25 clk = ~clk;

   sltps_top dut (.clk(clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
                  .conv_data(conv_data), .lane_out(lane_out));
   sltps_rx_model rx (.clk(clk), .rst_n(rst_n), .lane(lane_out[0]), .tap_a(tap_a),
                      .tap_b(tap_b), .bad_cnt(bad_cnt), .word_cnt(word_cnt));

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Classic cycle: hold until ack is sampled, then release
   task wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] d);
      @(posedge clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
      do @(posedge clk); while (wb_rsp.ack !== 1'b1);
      rd = wb_rsp.dat;
      wb_req <= '0;
   endtask : wb_xfer

   // Select changes only with the link disabled
   task set_pat(input logic [4:0] code, input logic enc);
      wb_xfer(1'b1, 4'h4, {30'h0, enc, 1'b0});
      wb_xfer(1'b1, 4'h0, {27'h0, code});
      wb_xfer(1'b1, 4'h4, {30'h0, enc, 1'b1});
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask : set_pat

   task chk_all(input logic [18:0] exp);
      for (int i = 0; i < NUM_LANES; i++) begin
         chk({13'h0, lane_out[i]}, {13'h0, exp});
      end
   endtask : chk_all

   task chk_conv;
      for (int i = 0; i < NUM_LANES; i++) begin
         chk({13'h0, lane_out[i]}, {13'h0, conv_data[i], 3'b000});
      end
   endtask : chk_conv

   // Bounded search on lane 0, a miss is a mismatch
   task find(input logic [18:0] mask, input logic [18:0] val);
      int n;
      n = 0;
      while (({13'h0, lane_out[0]} & mask) !== val && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk(n < 40, 1'b1);
   endtask : find

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task t_regs;
      wb_xfer(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h0);
      wb_xfer(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h2);
      wb_xfer(1'b1, 4'h8, 32'h1f);
      wb_xfer(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h0);
      wb_xfer(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0);
      @(negedge clk);
      chk_all(19'h0);
      $display("test regs done");
   endtask : t_regs

   task t_normal;
      set_pat(PAT_NORMAL, 1'b1);
      chk_conv();
      wb_xfer(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h100);
      $display("test normal done");
   endtask : t_normal

   // Fixed words, then codes that fall back to converter data
   task t_fixed;
      logic [4:0]  c [6];
      logic [18:0] e [6];
      c = '{PAT_D21_5, PAT_K28_5, PAT_LOW, PAT_HIGH, PAT_CLOCK, PAT_K28_7};
      // Data characters carry no K flag; raw words bypass the encoder
      e = '{{CH_D21_5, CH_D21_5, 3'b000}, {CH_K28_5, CH_K28_5, 3'b110}, 19'h00001,
            19'h7fff9, {CLK_WORD, 3'b001}, {CH_K28_7, CH_K28_7, 3'b110}};
      for (int i = 0; i < 6; i++) begin
         set_pat(c[i], 1'b1);
         chk_all(e[i]);
         @(negedge clk);
         chk_all(e[i]);
      end
      c = '{PAT_K28_5, PAT_ILA, PAT_RPAT, PAT_K28_7, 5'h0c, 5'h11};
      for (int i = 0; i < 6; i++) begin
         set_pat(c[i], i > 3);
         chk_conv();
      end
      $display("test fixed done");
   endtask : t_fixed

   task t_prbs;
      logic [4:0] c [5];
      logic [4:0] a [5];
      logic [4:0] b [5];
      int         b0;
      int         w0;
      c = '{PAT_PRBS7, PAT_PRBS15, PAT_PRBS23, PAT_PRBS9, PAT_PRBS31};
      a = '{5'd7, 5'd15, 5'd23, 5'd9, 5'd31};
      b = '{5'd6, 5'd14, 5'd18, 5'd5, 5'd28};
      for (int i = 0; i < 5; i++) begin
         tap_a <= a[i];
         tap_b <= b[i];
         set_pat(c[i], 1'b1);
         // Baseline once the new sequence runs; old words met the new taps
         b0 = bad_cnt;
         w0 = word_cnt;
         repeat (40) @(negedge clk);
         chk({13'h0, lane_out[3]}, {13'h0, lane_out[0]});
         chk(lane_out[0].raw, 1'b1);
         chk(bad_cnt - b0, 32'h0);
         chk(word_cnt - w0 > 30, 1'b1);
      end
      $display("test prbs done");
   endtask : t_prbs

   task t_seq;
      logic [15:0] p;
      set_pat(PAT_RAMP, 1'b1);
      p = lane_out[1].data;
      chk({24'h0, p[7:0]}, {24'h0, p[15:8] + 8'h1});
      @(negedge clk);
      chk({24'h0, lane_out[1].data[15:8]}, {24'h0, p[15:8] + 8'h2});
      set_pat(PAT_TRANSPORT, 1'b1);
      p = lane_out[0].data;
      for (int i = 0; i < NUM_LANES; i++) begin
         chk({24'h0, lane_out[i].data[15:8]}, {24'h0, 4'(i), 4'h0});
      end
      @(negedge clk);
      chk({24'h0, lane_out[0].data[7:0]}, {24'h0, p[7:0] + 8'h2});
      set_pat(PAT_ILA, 1'b1);
      // Start marker: upper octet K28.0 with its K flag, low octet ignored
      find(19'h7f806, {8'h1c, 11'h004});
      repeat (15) @(negedge clk);
      chk({13'h0, lane_out[0]} & 32'h7fe, {8'h7c, 3'b010});
      @(negedge clk);
      chk({13'h0, lane_out[0]} & 32'h7f806, {8'h1c, 11'h004});
      set_pat(PAT_RPAT, 1'b1);
      find(19'h7fff8, {RPAT_TBL[0], 3'b000});
      for (int j = 1; j < 7; j++) begin
         @(negedge clk);
         chk({16'h0, lane_out[0].data}, {16'h0, RPAT_TBL[j % 6]});
      end
      $display("test sequences done");
   endtask : t_seq

   // ------------------------------------------------------------------
   // Hang guard and main sequence
   // ------------------------------------------------------------------
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 8000) begin
         err_count++;
         tally_and_finish();
      end
   end

   initial begin
      rst_n = 1'b0;
      wb_req = '0;
      tap_a = 5'd7;
      tap_b = 5'd6;
      conv_data = {16'h4c4d, 16'h3a3b, 16'h2829, 16'h1617};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_normal();
      t_fixed();
      t_prbs();
      t_seq();
      tally_and_finish();
   end
endmodule : serial_lane_test_pattern_select_tb_top
